// >>> hw/pbu_blend_unit.sv
// pixel blend unit: four blend lanes with two-cycle loop-back control
module pbu_blend_unit
    import pbu_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // controller pins
    input wire pbu_pins_t pins,
    // blend configuration
    input wire pbu_cfg_t cfg,
    // pixel buffer old data and constant source
    input wire logic [31:0] old_data,
    input wire logic [35:0] const_source,
    // pass condition from the compare units
    input wire logic pass_condition,
    // write towards the pixel buffer
    output pbu_wr_t pbuf_write,
    // status
    output logic two_cycle_armed,
    output logic lane3_blend_blocked
);

    // ------------------------------------------------------------
    // sequencing state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PBU_ST_SINGLE = 2'b01,
        PBU_ST_ARMED = 2'b10
    } pbu_state_t;

    typedef struct packed {
        pbu_state_t state;
        logic [PBU_LANES-1:0][7:0] loop_prod;
        logic [PBU_LANES-1:0][8:0] loop_add;
        pbu_wr_t wr;
    } pbu_regs_t;

    pbu_regs_t r_q;
    pbu_regs_t r_d;

    logic is_init;
    logic is_write;
    logic preblend;
    logic loop_normal;
    logic [PBU_LANES-1:0] lane_blend;
    logic [PBU_LANES-1:0][7:0] lane_result;
    logic [PBU_LANES-1:0][7:0] lane_product;
    logic [PBU_LANES-1:0][8:0] lane_addend;
    logic [PBU_LANES-1:0][7:0] lane_alpha_sat;
    logic [7:0] alpha_sat;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    // initiate needs write enable; a plain read of opcode 110 does nothing
    assign is_init = pins.alu_write_enable && (pins.alu_opcode == PBU_OP_INIT_TWO_CYCLE);
    assign is_write = pins.alu_write_enable && (pins.alu_opcode == PBU_OP_STATEFUL_WRITE);
    assign preblend = is_init;
    // only the first write after an initiate takes the loop-back addend, even with idle cycles between
    assign loop_normal = is_write && (r_q.state == PBU_ST_ARMED);

    // lane 3 shares its path with the stencil logic, so stencil mode locks it out
    always_comb begin
        lane_blend = cfg.lane_function_select;
        if (cfg.stencil_mode) begin
            lane_blend[PBU_ALPHA_LANE] = 1'b0;
        end
    end

    // alpha-saturate term comes only from the alpha lane
    assign alpha_sat = lane_alpha_sat[PBU_ALPHA_LANE];

    // ------------------------------------------------------------
    // lanes
    // ------------------------------------------------------------
    // lanes 0..2 are the same; lane 3 adds the alpha-saturate circuit
    for (genvar i = 0; i < PBU_LANES; i++) begin : g_lane
        pbu_lane #(
            .HAS_ALPHA_SAT(i == PBU_ALPHA_LANE)
        ) u_lane (
            .pin_byte(pins.alu_data_pins[8*i +: 8]),
            .pin_ext(pins.alu_extension_pins[i]),
            .old_byte(old_data[8*i +: 8]),
            .k_byte(const_source[8*i +: 8]),
            .k_ext(const_source[32+i]),
            .pin_alpha(pins.alu_data_pins[31:24]),
            .pin_alpha_ext(pins.alu_extension_pins[PBU_ALPHA_LANE]),
            .old_alpha(old_data[31:24]),
            .alpha_sat_in(alpha_sat),
            .cfg(cfg),
            .preblend(preblend),
            .loop_normal(loop_normal),
            .loop_prod(r_q.loop_prod[i]),
            .loop_add(r_q.loop_add[i]),
            .result(lane_result[i]),
            .product(lane_product[i]),
            .addend(lane_addend[i]),
            .alpha_sat_out(lane_alpha_sat[i])
        );
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // write strobe is one cycle; loop-back registers hold until the next preblend
    always_comb begin
        r_d = r_q;
        r_d.wr.valid = 1'b0;
        case (r_q.state)
            PBU_ST_SINGLE: begin
                if (is_init) begin
                    r_d.state = PBU_ST_ARMED;
                end
            end
            PBU_ST_ARMED: begin
                // the stateful write consumes the loop-back; a new initiate re-arms
                if (is_write) begin
                    r_d.state = PBU_ST_SINGLE;
                end
            end
            default: begin
                r_d.state = PBU_ST_SINGLE;
            end
        endcase
        // preblend: keep product and addend one stage for the next cycle
        if (preblend) begin
            r_d.loop_prod = lane_product;
            r_d.loop_add = lane_addend;
        end
        // every stateful write produces a result in one cycle, which gives the
        // single-cycle throughput of the half blends
        if (is_write) begin
            r_d.wr.addr = pins.alu_pixel_address;
            r_d.wr.data = old_data;
            r_d.wr.be = 4'h0;
            // nothing reaches the pixel buffer unless the pass condition holds
            r_d.wr.valid = pass_condition;
            for (int i = 0; i < PBU_LANES; i++) begin
                if (lane_blend[i]) begin
                    r_d.wr.data[8*i +: 8] = lane_result[i];
                    r_d.wr.be[i] = pins.alu_byte_enables[i] && pass_condition;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            r_q <= '0;
            r_q.state <= PBU_ST_SINGLE;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pbuf_write = r_q.wr;
    assign two_cycle_armed = (r_q.state == PBU_ST_ARMED);
    assign lane3_blend_blocked = cfg.stencil_mode;

endmodule : pbu_blend_unit

// >>> common/pbu_pkg.sv
// pixel blend unit shared constants, types and helper functions
package pbu_pkg;

    // ------------------------------------------------------------
    // widths and pin encodings
    // ------------------------------------------------------------
    localparam int unsigned PBU_LANES = 4;
    localparam int unsigned PBU_ADDR_W = 9;
    localparam int unsigned PBU_ALPHA_LANE = 3;
    localparam logic [2:0] PBU_OP_INIT_TWO_CYCLE = 3'h6;
    localparam logic [2:0] PBU_OP_STATEFUL_WRITE = 3'h2;

    // ------------------------------------------------------------
    // operand select encodings and numeric limits
    // ------------------------------------------------------------
    localparam logic [2:0] PBU_FRAC_PIN = 3'h0;
    localparam logic [2:0] PBU_FRAC_PIN_ALPHA = 3'h1;
    localparam logic [2:0] PBU_FRAC_OLD = 3'h2;
    localparam logic [2:0] PBU_FRAC_CONST = 3'h3;
    localparam logic [2:0] PBU_FRAC_UNITY = 3'h4;
    localparam logic [2:0] PBU_DT_OLD = 3'h0;
    localparam logic [2:0] PBU_DT_OLD_INV = 3'h1;
    localparam logic [2:0] PBU_DT_ALPHA_SAT = 3'h2;
    localparam logic [2:0] PBU_DT_PIN_ALPHA = 3'h3;
    localparam logic [2:0] PBU_DT_OLD_ALPHA = 3'h4;
    localparam logic [2:0] PBU_DT_OLD_ALPHA_INV = 3'h5;
    localparam logic [1:0] PBU_ADD_PIN = 2'h0;
    localparam logic [1:0] PBU_ADD_CONST = 2'h1;
    localparam logic [1:0] PBU_ADD_OLD = 2'h2;
    localparam logic [8:0] PBU_FRAC_ONE = 9'h100;
    localparam logic [7:0] PBU_BYTE_MAX = 8'hff;
    localparam logic [3:0] PBU_NIB_ZERO = 4'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] alu_opcode;
        logic alu_write_enable;
        logic [PBU_ADDR_W-1:0] alu_pixel_address;
        logic [3:0] alu_byte_enables;
        logic [31:0] alu_data_pins;
        logic [3:0] alu_extension_pins;
    } pbu_pins_t;

    typedef struct packed {
        logic [3:0] lane_function_select;  // 1 = blend, 0 = raster op
        logic [2:0] frac_sel;
        logic [2:0] dterm_sel;
        logic [1:0] addend_sel;
        logic [2:0] pre_dterm_sel;
        logic pre_loop_product;             // 1 = product, 0 = addend
        logic nibble_mode;
        logic nibble_zero_fill;
        logic stencil_mode;
    } pbu_cfg_t;

    typedef struct packed {
        logic valid;
        logic [PBU_ADDR_W-1:0] addr;
        logic [3:0] be;
        logic [31:0] data;
    } pbu_wr_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // 4-bit colour to 8 bits: duplicate or zero-fill the low nibble
    function automatic logic [7:0] pbu_expand(input logic [3:0] nib, input logic zero_fill);
        pbu_expand = zero_fill ? {nib, PBU_NIB_ZERO} : {nib, nib};
    endfunction : pbu_expand

    // squeeze a signed 10-bit sum into 0..255
    function automatic logic [7:0] pbu_clamp(input logic signed [9:0] v);
        if (v < 0) begin
            pbu_clamp = 8'h00;
        end else if (v > $signed({2'b00, PBU_BYTE_MAX})) begin
            pbu_clamp = PBU_BYTE_MAX;
        end else begin
            pbu_clamp = v[7:0];
        end
    endfunction : pbu_clamp

endpackage : pbu_pkg

// >>> hw/pbu_lane.sv
// one 8-bit blend lane: operand muxes, multiplier, adder and clamp
module pbu_lane
    import pbu_pkg::*;
#(
    parameter bit HAS_ALPHA_SAT = 1'b0
) (
    // lane operands
    input wire logic [7:0] pin_byte,
    input wire logic pin_ext,
    input wire logic [7:0] old_byte,
    input wire logic [7:0] k_byte,
    input wire logic k_ext,
    // alpha lane operands shared by all lanes
    input wire logic [7:0] pin_alpha,
    input wire logic pin_alpha_ext,
    input wire logic [7:0] old_alpha,
    input wire logic [7:0] alpha_sat_in,
    // control
    input wire pbu_cfg_t cfg,
    input wire logic preblend,
    input wire logic loop_normal,
    input wire logic [7:0] loop_prod,
    input wire logic [8:0] loop_add,
    // results
    output logic [7:0] result,
    output logic [7:0] product,
    output logic [8:0] addend,
    output logic [7:0] alpha_sat_out
);

    logic [7:0] n_x;
    logic [7:0] o_x;
    logic [8:0] frac_raw;
    logic [8:0] frac;
    logic [7:0] dterm;
    logic [2:0] dsel;
    logic [16:0] mult;
    logic signed [9:0] inter;
    logic [7:0] clamped;

    // 4-bit colour mode widens pin and old bytes before they enter the path
    assign n_x = cfg.nibble_mode ? pbu_expand(pin_byte[3:0], cfg.nibble_zero_fill) : pin_byte;
    assign o_x = cfg.nibble_mode ? pbu_expand(old_byte[3:0], cfg.nibble_zero_fill) : old_byte;

    // alpha-saturate exists only in the alpha lane; 1-x is the bitwise inverse
    assign alpha_sat_out = HAS_ALPHA_SAT ? ((pin_alpha < ~old_alpha) ? pin_alpha : ~old_alpha)
                                         : 8'h00;

    // fraction operand: preblend always takes the pin bus
    always_comb begin
        if (preblend) begin
            frac_raw = {pin_ext, n_x};
        end else begin
            case (cfg.frac_sel)
                PBU_FRAC_PIN: frac_raw = {pin_ext, n_x};
                PBU_FRAC_PIN_ALPHA: frac_raw = {pin_alpha_ext, pin_alpha};
                PBU_FRAC_OLD: frac_raw = {1'b0, o_x};
                PBU_FRAC_CONST: frac_raw = {k_ext, k_byte};
                default: frac_raw = PBU_FRAC_ONE;
            endcase
        end
        // anything above unity is held at unity
        frac = (frac_raw > PBU_FRAC_ONE) ? PBU_FRAC_ONE : frac_raw;
    end

    // data term operand: preblend select or the normal select
    assign dsel = preblend ? cfg.pre_dterm_sel : cfg.dterm_sel;
    always_comb begin
        case (dsel)
            PBU_DT_OLD: dterm = o_x;
            PBU_DT_OLD_INV: dterm = ~o_x;
            PBU_DT_ALPHA_SAT: dterm = alpha_sat_in;
            PBU_DT_PIN_ALPHA: dterm = pin_alpha;
            PBU_DT_OLD_ALPHA: dterm = old_alpha;
            PBU_DT_OLD_ALPHA_INV: dterm = ~old_alpha;
            default: dterm = o_x;
        endcase
    end

    // addend: pins in preblend, loop-back in the normal cycle, else the select
    always_comb begin
        if (preblend) begin
            addend = {pin_ext, n_x};
        end else if (loop_normal) begin
            addend = cfg.pre_loop_product ? {1'b0, loop_prod} : loop_add;
        end else begin
            case (cfg.addend_sel)
                PBU_ADD_PIN: addend = {pin_ext, n_x};
                PBU_ADD_CONST: addend = {k_ext, k_byte};
                PBU_ADD_OLD: addend = {1'b0, o_x};
                default: addend = {pin_ext, n_x};
            endcase
        end
    end

    // fraction is 1.8 fixed point, so the product keeps bits 15:8
    // both operands widened to the full product width so no product bit is lost
    assign mult = {8'h00, frac} * {9'h000, dterm};
    assign product = mult[15:8];
    assign inter = $signed({2'b00, product}) + $signed({addend[8], addend});
    assign clamped = pbu_clamp(inter);
    // 4-bit mode drops the low nibble of the result
    assign result = cfg.nibble_mode ? {PBU_NIB_ZERO, clamped[7:4]} : clamped;

endmodule : pbu_lane

// >>> testbench/pbu_blend_unit_assertions.sv
// concurrent checks on the pixel blend unit ports
module pbu_blend_unit_assertions
    import pbu_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // unit inputs
    input wire pbu_pins_t pins,
    input wire pbu_cfg_t cfg,
    input wire logic [31:0] old_data,
    input wire logic pass_condition,
    // unit outputs
    input wire pbu_wr_t pbuf_write,
    input wire logic two_cycle_armed,
    input wire logic lane3_blend_blocked
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic [3:0] be_exp_q;
    logic [7:0] old3_q;
    // expected lane gating and alpha byte, one cycle behind the request
    always_ff @(posedge mclk) begin
        be_exp_q <= pins.alu_byte_enables & cfg.lane_function_select & {~cfg.stencil_mode, 3'h7};
        old3_q <= old_data[31:24];
    end
    // ------------------------------------------------------------
    // request sequences
    // ------------------------------------------------------------
    sequence s_init;
        pins.alu_write_enable && pins.alu_opcode == PBU_OP_INIT_TWO_CYCLE;
    endsequence
    sequence s_write;
        pins.alu_write_enable && pins.alu_opcode == PBU_OP_STATEFUL_WRITE;
    endsequence
    a_write_valid: assert property (s_write ##0 pass_condition |=> pbuf_write.valid)
        else $error("write not issued one cycle after a stateful write");
    a_pass_gate: assert property (s_write ##0 !pass_condition |=> !pbuf_write.valid
        && pbuf_write.be == 4'h0) else $error("write issued without pass");
    a_no_stray: assert property (!(pins.alu_write_enable && pins.alu_opcode ==
        PBU_OP_STATEFUL_WRITE) |=> !pbuf_write.valid) else $error("stray write");
    a_addr_follow: assert property (pbuf_write.valid |->
        pbuf_write.addr == $past(pins.alu_pixel_address)) else $error("write address wrong");
    a_arm_init: assert property (s_init |=> two_cycle_armed)
        else $error("initiate did not arm");
    a_two_cycle: assert property (s_init ##1 (s_write ##0 pass_condition)
        |=> pbuf_write.valid && !two_cycle_armed) else $error("two-cycle write wrong");
    a_stay_idle: assert property (!two_cycle_armed && !pins.alu_write_enable
        |=> !two_cycle_armed) else $error("armed without initiate");
    a_lane_gate: assert property (s_write ##0 pass_condition |=>
        pbuf_write.be == be_exp_q) else $error("byte enables not gated by lane mode");
    a_lane3_old: assert property (s_write ##0 cfg.stencil_mode
        |=> pbuf_write.data[31:24] == old3_q) else $error("alpha lane blended under stencil");
    a_block_flag: assert property (lane3_blend_blocked == cfg.stencil_mode)
        else $error("alpha lane block flag wrong");
endmodule : pbu_blend_unit_assertions

// >>> testbench/pbu_ctrl_model.sv
// rendering controller model driving the pixel ALU pins
module pbu_ctrl_model
    import pbu_pkg::*;
(
    // clock
    input wire logic mclk,
    // pins towards the unit
    output pbu_pins_t pins
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pins = '0;
    // request starts just after an edge and holds until the taking edge
    task automatic issue(input logic [2:0] op, input logic [8:0] a, input logic [3:0] be,
                         input logic [31:0] dq, input logic [3:0] dx);
        pins = '{op, 1'b1, a, be, dq, dx};
        @(posedge mclk);
        #1;
    endtask : issue
    // released data lines toggle so a stale value never looks valid
    task automatic idle();
        pins.alu_write_enable = 1'b0;
        pins.alu_data_pins = ~pins.alu_data_pins;
        pins.alu_extension_pins = ~pins.alu_extension_pins;
        @(posedge mclk);
        #1;
    endtask : idle
endmodule : pbu_ctrl_model

// >>> testbench/testbench.sv
// self-checking bench for the pixel blend unit
module testbench import pbu_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [2:0] f; logic [2:0] d; logic [1:0] a; logic [31:0] n; logic [3:0] x;
        logic [31:0] o;
    } pbu_row_t;
    localparam pbu_row_t ROWS [6] = '{
        '{3'h0, 3'h0, 2'h0, 32'h8040_2010, 4'h0, 32'h1122_3344},
        '{3'h1, 3'h1, 2'h1, 32'h7f00_ff01, 4'h8, 32'h0f1e_2d3c},
        '{3'h2, 3'h2, 2'h2, 32'h4000_0000, 4'h0, 32'hc0ff_80a0},
        '{3'h3, 3'h3, 2'h0, 32'h9080_7060, 4'h5, 32'h0000_0000},
        '{3'h4, 3'h4, 2'h1, 32'h00ff_00ff, 4'h0, 32'hff00_ff00},
        '{3'h0, 3'h5, 2'h2, 32'hff10_2030, 4'hf, 32'h5566_7788}};
    logic mclk = 1'b0;
    logic srst = 1'b1;
    pbu_pins_t pins;
    pbu_cfg_t cfg;
    logic [31:0] old_data = 32'h0;
    logic [35:0] const_source = 36'h3_40ff_8001;
    logic pass_condition = 1'b1;
    pbu_wr_t pbuf_write;
    logic two_cycle_armed;
    logic lane3_blend_blocked;
    int n_fail = 0;
    int checks = 0;
    initial forever #25 mclk = ~mclk;
    pbu_blend_unit dut_u (.mclk(mclk), .srst(srst), .pins(pins), .cfg(cfg),
        .old_data(old_data), .const_source(const_source), .pass_condition(pass_condition),
        .pbuf_write(pbuf_write), .two_cycle_armed(two_cycle_armed),
        .lane3_blend_blocked(lane3_blend_blocked));
    pbu_ctrl_model ctrl_u (.mclk(mclk), .pins(pins));
    // ------------------------------------------------------------
    // reference maths
    // ------------------------------------------------------------
    function automatic logic [7:0] prod(logic [8:0] f, logic [7:0] d);
        f = (f > 9'h100) ? 9'h100 : f;
        return 8'((17'(f) * d) >> 8);
    endfunction : prod
    function automatic logic [31:0] nib(logic [31:0] v);
        for (int i = 0; i < 4; i++) begin
            v[8*i+:8] = {v[8*i+:4], cfg.nibble_zero_fill ? 4'h0 : v[8*i+:4]};
        end
        return v;
    endfunction : nib
    // data term; one-minus terms are plain inversions
    function automatic logic [7:0] dsel(logic [2:0] s, logic [7:0] oi, logic [31:0] n,
                                        logic [31:0] o);
        case (s)
            3'h0: return oi;
            3'h1: return ~oi;
            3'h2: return (n[31:24] < ~o[31:24]) ? n[31:24] : ~o[31:24];
            3'h3: return n[31:24];
            3'h4: return o[31:24];
            default: return ~o[31:24];
        endcase
    endfunction : dsel
    function automatic logic [31:0] exp_data(logic [31:0] n, logic [3:0] x, logic [31:0] o,
                                             logic two, logic [31:0] pn, logic [3:0] px);
        logic [31:0] r, ro;
        logic [8:0] f, a;
        logic signed [10:0] s;
        ro = o;
        if (cfg.nibble_mode) begin
            n = nib(n);
            o = nib(o);
            pn = nib(pn);
        end
        for (int i = 0; i < 4; i++) begin
            case (cfg.frac_sel)
                3'h0: f = {x[i], n[8*i+:8]};
                3'h1: f = {x[3], n[31:24]};
                3'h2: f = {1'b0, o[8*i+:8]};
                3'h3: f = {const_source[32+i], const_source[8*i+:8]};
                default: f = 9'h100;
            endcase
            case (cfg.addend_sel)
                2'h0: a = {x[i], n[8*i+:8]};
                2'h1: a = {const_source[32+i], const_source[8*i+:8]};
                default: a = {1'b0, o[8*i+:8]};
            endcase
            if (two) begin
                a = {px[i], pn[8*i+:8]};
                if (cfg.pre_loop_product) begin
                    a = {1'b0, prod(a, dsel(cfg.pre_dterm_sel, o[8*i+:8], pn, o))};
                end
            end
            s = 11'(prod(f, dsel(cfg.dterm_sel, o[8*i+:8], n, o))) + 11'($signed(a));
            r[8*i+:8] = (s < 0) ? 8'h00 : (s > 255) ? 8'hff : s[7:0];
            if (cfg.nibble_mode) r[8*i+:8] = {4'h0, r[8*i+4+:4]};
            if (!cfg.lane_function_select[i] || (i == 3 && cfg.stencil_mode)) begin
                r[8*i+:8] = ro[8*i+:8];
            end
        end
        return r;
    endfunction : exp_data
    // ------------------------------------------------------------
    // checking and stimulus
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    // one blend, optionally preceded by the initiate cycle on the same pixel
    task automatic run(input logic two, input logic [31:0] n, input logic [3:0] x,
                       input logic [31:0] o, input logic [31:0] pn, input logic [3:0] px);
        old_data = o;
        if (two) begin
            ctrl_u.issue(PBU_OP_INIT_TWO_CYCLE, 9'h0a5, 4'hf, pn, px);
            check(32'(two_cycle_armed), 32'h1);
        end
        ctrl_u.issue(PBU_OP_STATEFUL_WRITE, 9'h0a5, 4'hf, n, x);
        check(32'(pbuf_write.valid), 32'(pass_condition));
        check(32'(pass_condition ? 4'h0 : pbuf_write.be), 32'h0);
        check(32'(pass_condition ? pbuf_write.be : 4'h0), 32'(pass_condition ?
            cfg.lane_function_select & {~cfg.stencil_mode, 3'h7} : 4'h0));
        check(pbuf_write.data, exp_data(n, x, o, two, pn, px));
        check(32'(two_cycle_armed), 32'h0);
        ctrl_u.idle();
    endtask : run
    initial begin
        cfg = '{4'hf, 3'h4, 3'h0, 2'h0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0};
        repeat (5) @(posedge mclk);
        #1;
        srst = 1'b0;
        check({pbuf_write.valid, pbuf_write.be, two_cycle_armed}, 32'h0);
        foreach (ROWS[k]) begin
            {cfg.frac_sel, cfg.dterm_sel, cfg.addend_sel} = {ROWS[k].f, ROWS[k].d, ROWS[k].a};
            run(1'b0, ROWS[k].n, ROWS[k].x, ROWS[k].o, 32'h0, 4'h0);
        end
        for (int k = 0; k < 2; k++) begin
            cfg.pre_loop_product = k[0];
            cfg.pre_dterm_sel = 3'(k + 1);
            run(1'b1, 32'h1234_5678, 4'h0, 32'h9abc_def0, 32'hc080_4020, 4'h0);
        end
        pass_condition = 1'b0;
        run(1'b0, 32'h0102_0304, 4'h2, 32'h4433_2211, 32'h0, 4'h0);
        pass_condition = 1'b1;
        cfg.stencil_mode = 1'b1;
        cfg.lane_function_select = 4'hd;
        // flag is looked at after an edge, never in the step that changed the config
        run(1'b0, 32'h7766_5544, 4'h0, 32'h3388_99aa, 32'h0, 4'h0);
        check(32'(lane3_blend_blocked), 32'h1);
        cfg = '{4'hf, 3'h2, 3'h1, 2'h2, 3'h0, 1'b1, 1'b1, 1'b0, 1'b0};
        for (int k = 0; k < 2; k++) begin
            cfg.nibble_zero_fill = k[0];
            run(1'b0, 32'h0000_0000, 4'h0, 32'h0a05_0c03, 32'h0, 4'h0);
        end
        for (int op = 0; op < 8; op++) begin
            if (op == 2 || op == 6) continue;
            ctrl_u.issue(3'(op), 9'h011, 4'hf, 32'h5a5a_5a5a, 4'h0);
            check(32'(pbuf_write.valid), 32'h0);
        end
        ctrl_u.issue(PBU_OP_INIT_TWO_CYCLE, 9'h011, 4'hf, 32'h0, 4'h0);
        srst = 1'b1;
        ctrl_u.idle();
        srst = 1'b0;
        check({pbuf_write.valid, two_cycle_armed}, 32'h0);
        final_report();
    end
endmodule : testbench
bind pbu_blend_unit pbu_blend_unit_assertions chk_u (.mclk(mclk), .srst(srst), .pins(pins),
    .cfg(cfg), .old_data(old_data), .pass_condition(pass_condition), .pbuf_write(pbuf_write),
    .two_cycle_armed(two_cycle_armed), .lane3_blend_blocked(lane3_blend_blocked));
